// ==== verif/encoder_fault_speed_regulator_sva.sv ====
// Purpose: port checks on bus handshakes and drive actions
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every regulator instance
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module encoder_fault_speed_regulator_chk #(
  parameter TICK_CYCLES = 100000,
  parameter IDX_WIN = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus handshakes
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // drive side
  input wire [15:0] meas_speed,
  input wire warn_r,
  input wire ramp_stop_r,
  input wire coast_stop_r,
  input wire gain_sel_r,
  input wire irq_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a stop request never stands without its warning
  ramp_warn_a: assert property (ramp_stop_r |-> warn_r)
    else $error("ramp stop without warning");
  coast_warn_a: assert property (coast_stop_r |-> warn_r)
    else $error("coast stop without warning");
  // set two needs speed above a nonzero threshold; pipeline may add a stage
  gain_speed_a: assert property (gain_sel_r |->
    ($past(meas_speed) > 16'h0001) || ($past(meas_speed, 2) > 16'h0001))
    else $error("gain set two at standstill");
  // ready strobes last one cycle
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held");
  // responses leave after their handshake; read data follows the address handshake next cycle
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  warn_c: cover property ($rose(warn_r));
  gain_c: cover property ($rose(gain_sel_r));
  irq_c: cover property ($rose(irq_r));
endmodule // encoder_fault_speed_regulator_chk

bind encoder_fault_speed_regulator encoder_fault_speed_regulator_chk #(
  .TICK_CYCLES(TICK_CYCLES), .IDX_WIN(IDX_WIN)) i_encoder_fault_speed_regulator_chk (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .meas_speed,
  .warn_r, .ramp_stop_r, .coast_stop_r, .gain_sel_r, .irq_r);

// ==== verif/encoder_fault_speed_regulator_tb_top.sv ====
// Purpose: self-checking bench for the feedback supervisor and regulator
// Assumes: 1 ms tick shortened to 10 clocks, encoder model on the pins
// Notes:   speeds in 0.01 Hz, max frequency fixed at 10.00 Hz
`timescale 1ns/1ps
module encoder_fault_speed_regulator_tb_top;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  reg aclk = 1'h0, aresetn = 1'h0, feedback_loss = 1'h0, run = 1'h0, idx_rise = 1'h0;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  reg [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [15:0] meas_speed = 16'h03e8, cmd_freq = 16'h03e8, max_freq = 16'h03e8;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, speed_out_r;
  wire enc_index, enc_u, enc_v, warn_r, ramp_stop_r, coast_stop_r, gain_sel_r, irq_r;
  integer fails = 0, compares = 0;
  always #5 aclk = ~aclk;
  encoder_fault_speed_regulator #(.TICK_CYCLES(10), .IDX_WIN(16)) i_encoder_fault_speed_regulator (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_speed, .cmd_freq, .max_freq,
    .enc_index, .enc_u, .enc_v, .feedback_loss, .warn_r, .ramp_stop_r, .coast_stop_r,
    .gain_sel_r, .speed_out_r, .irq_r);
  encoder_pins_model #(.STEP(4)) i_encoder_pins_model (
    .aclk, .run, .idx_rise, .enc_index, .enc_u, .enc_v);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    begin
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic tmo;
    begin
      fails = fails + 1;
      $display("MISMATCH t=%0t wait ran out", $time);
      test_done;
    end
  endtask
  // trailing edge after release keeps back-to-back calls off one time step
  task automatic wr(input [5:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; !s_axi_bvalid && n < 50; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end
      if (n >= 50) tmo;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
      s_axi_bready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task automatic rd(input [5:0] a, input [31:0] e, input [1:0] r);
    integer n;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; !s_axi_rvalid && n < 50; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      if (n >= 50) tmo;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
      s_axi_rready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task automatic wait_warn(output integer n);
    begin
      for (n = 0; warn_r !== 1'h1 && n < 200; n = n + 1) @(posedge aclk);
      if (n >= 200) tmo;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    begin
      rd(6'h00, 32'h0a, 2'h0);
      rd(6'h04, 32'h73, 2'h0);
      rd(6'h0c, 32'h64, 2'h0);
      rd(6'h14, 32'h2bc, 2'h0);
      rd(6'h38, 32'h0, 2'h2);
      wr(6'h3c, 32'h1, 2'h2);
      wr(6'h04, 32'h7f, 2'h0);
      rd(6'h04, 32'h78, 2'h0);
      wr(6'h08, 32'h63, 2'h0);
      rd(6'h08, 32'h32, 2'h0);
      wr(6'h0c, 32'h2, 2'h0);
      wr(6'h10, 32'h2, 2'h0);
    end
  endtask
  // overspeed at 130 percent against a 120 percent level, each treatment
  task automatic t_stall;
    integer c, n;
    begin
      for (c = 0; c < 3; c = c + 1) begin
        wr(6'h00, c * 4 + 2, 2'h0);
        meas_speed <= 16'h0514;
        cmd_freq <= 16'h0514;
        wait_warn(n);
        chk(n > 14 && n < 60, 32'h1);
        chk({warn_r, ramp_stop_r, coast_stop_r}, {1'h1, c == 1, c == 2});
        rd(6'h28, 32'h4, 2'h0);
        meas_speed <= 16'h03e8;
        cmd_freq <= 16'h03e8;
        wr(6'h28, 32'h4, 2'h0);
        repeat (3) @(posedge aclk);
        chk(warn_r, 32'h0);
      end
      wr(6'h04, 32'h0, 2'h0);
      meas_speed <= 16'h0514;
      cmd_freq <= 16'h0514;
      repeat (100) @(posedge aclk);
      chk(warn_r, 32'h0);
      meas_speed <= 16'h03e8;
      cmd_freq <= 16'h03e8;
    end
  endtask
  // 2.00 Hz slip against a 10 percent range, raised and masked interrupt
  task automatic t_slip;
    integer n;
    begin
      wr(6'h08, 32'h0a, 2'h0);
      wr(6'h2c, 32'h08, 2'h0);
      meas_speed <= 16'h04b0;
      wait_warn(n);
      chk(irq_r, 32'h1);
      rd(6'h28, 32'h8, 2'h0);
      wr(6'h2c, 32'h0, 2'h0);
      repeat (2) @(posedge aclk);
      chk(irq_r, 32'h0);
      meas_speed <= 16'h03e8;
      wr(6'h28, 32'h8, 2'h0);
      wr(6'h08, 32'h0, 2'h0);
      meas_speed <= 16'h04b0;
      repeat (100) @(posedge aclk);
      chk(warn_r, 32'h0);
      meas_speed <= 16'h03e8;
    end
  endtask
  task automatic t_index;
    integer n;
    begin
      wr(6'h00, 32'h01, 2'h0);
      run <= 1'h1;
      repeat (150) @(posedge aclk);
      rd(6'h28, 32'h0, 2'h0);
      idx_rise <= 1'h1;
      wait_warn(n);
      chk({warn_r, ramp_stop_r}, 32'h3);
      rd(6'h28, 32'h12, 2'h0);
      wr(6'h00, 32'h11, 2'h0);
      repeat (100) @(posedge aclk);
      wr(6'h28, 32'h12, 2'h0);
      repeat (100) @(posedge aclk);
      rd(6'h28, 32'h0, 2'h0);
      run <= 1'h0;
      wr(6'h00, 32'h02, 2'h0);
      feedback_loss <= 1'h1;
      wait_warn(n);
      chk({warn_r, coast_stop_r}, 32'h3);
      rd(6'h28, 32'h1, 2'h0);
      feedback_loss <= 1'h0;
      wr(6'h28, 32'h1, 2'h0);
    end
  endtask
  // switch threshold 7.00 Hz: set two strictly above, zero disables
  task automatic t_gain;
    begin
      meas_speed <= 16'h02bd;
      cmd_freq <= 16'h02bd;
      repeat (3) @(posedge aclk);
      chk(gain_sel_r, 32'h1);
      meas_speed <= 16'h02bc;
      cmd_freq <= 16'h02bc;
      repeat (3) @(posedge aclk);
      chk(gain_sel_r, 32'h0);
      wr(6'h14, 32'h0, 2'h0);
      meas_speed <= 16'h0384;
      cmd_freq <= 16'h0384;
      repeat (3) @(posedge aclk);
      chk(gain_sel_r, 32'h0);
    end
  endtask
  // gain 1024/1024 on an error of 100: pure p, then integral grows
  task automatic t_reg;
    begin
      wr(6'h18, 32'h400, 2'h0);
      wr(6'h1c, 32'h0, 2'h0);
      meas_speed <= 16'h03e8;
      cmd_freq <= 16'h044c;
      repeat (60) @(posedge aclk);
      chk(speed_out_r, 32'h64);
      wr(6'h1c, 32'h1, 2'h0);
      repeat (60) @(posedge aclk);
      chk($signed(speed_out_r) > 32'sh64, 32'h1);
      wr(6'h20, 32'h400, 2'h0);
      wr(6'h24, 32'h0, 2'h0);
      wr(6'h14, 32'h2bc, 2'h0);
      repeat (60) @(posedge aclk);
      chk(speed_out_r, 32'h64);
      rd(6'h34, 32'h1, 2'h0);
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_stall;
    t_slip;
    t_index;
    t_gain;
    t_reg;
    test_done;
  end
endmodule // encoder_fault_speed_regulator_tb_top

// ==== verif/encoder_pins_model.sv ====
// Purpose: incremental encoder with index and u/v commutation pins
// Assumes: forward rotation only, fixed step period
// Notes:   idx_rise puts the index on the u rising edge instead of falling
`timescale 1ns/1ps
// ----------------------------------------
// commutation sequencer
// ----------------------------------------
module encoder_pins_model #(
  parameter STEP = 4
) (
  // clock
  input wire aclk,
  // bench control
  input wire run,
  input wire idx_rise,
  // encoder pins
  output reg enc_index = 1'h0,
  output reg enc_u = 1'h1,
  output reg enc_v = 1'h0
);
  reg [2:0] ph_r = 3'h0;
  reg [7:0] cnt_r = 8'h00;
  wire [2:0] nx = (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
  // six states u,v,w order; u falls entering 2, rises entering 5 with v low
  always @(posedge aclk) begin
    enc_index <= 1'h0;
    if (run) begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r == STEP - 1) begin
        cnt_r <= 8'h00;
        ph_r <= nx;
        enc_u <= (nx == 3'h0) || (nx == 3'h1) || (nx == 3'h5);
        enc_v <= (nx == 3'h1) || (nx == 3'h2) || (nx == 3'h3);
        // index lands in the same cycle as the chosen u edge
        enc_index <= idx_rise ? (nx == 3'h5) : (nx == 3'h2);
      end
    end
  end
endmodule // encoder_pins_model

// ==== verilog/encoder_fault_speed_regulator.v ====
// Purpose: encoder feedback supervision and two-set speed regulator
// Assumes: speeds in 0.01 Hz units, inputs synchronous to aclk
// Notes:   times held in milliseconds, gains in units of 1/1024
`timescale 1ns/1ps
`include "encoder_fault_speed_regulator_consts.vh"

// How it works
// (RULE_01) slip beyond range starts fault timing
// (RULE_02) speed beyond stall level starts fault timing
// (RULE_03) timed stall/slip past limit raises fault
// (RULE_04) stall/slip treatment: keep, ramp, coast
// (RULE_05) mode 0: index on U falling edge
// (RULE_06) mode 1: index on U rising edge
// (RULE_07) regulator sums proportional and integral terms
// (RULE_08) zero integral time disables integral action
// (RULE_09) switch frequency picks gain set; zero disables
// (RULE_10) lasting loss or signal error raises fault
// (RULE_11) zero stall level or slip range disables
module encoder_fault_speed_regulator #(
  parameter TICK_CYCLES = `MS_TICK_CYCLES,
  parameter IDX_WIN = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // speed inputs
  input wire [15:0] meas_speed,
  input wire [15:0] cmd_freq,
  input wire [15:0] max_freq,
  // encoder pins
  input wire enc_index,
  input wire enc_u,
  input wire enc_v,
  input wire feedback_loss,
  // drive actions
  output reg warn_r,
  output reg ramp_stop_r,
  output reg coast_stop_r,
  output reg gain_sel_r,
  output reg [31:0] speed_out_r,
  output reg irq_r
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [1:0] fb_treat_r;
  reg [1:0] ss_treat_r;
  reg comm_mode_r;
  reg [6:0] stall_lvl_r;
  reg [6:0] slip_rng_r;
  reg [13:0] stall_time_r;
  reg [13:0] fb_time_r;
  reg [15:0] sw_freq_r;
  reg [12:0] kp1_r;
  reg [13:0] ti1_r;
  reg [12:0] kp2_r;
  reg [13:0] ti2_r;
  reg [`ST_W-1:0] status_r;
  reg [`ST_W-1:0] mask_r;
  reg aw_got_r;
  reg w_got_r;
  reg [5:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  // clamp a written value to its upper bound
  function [13:0] clamp14;
    input [13:0] v;
    input [13:0] lim;
    begin
      clamp14 = (v > lim) ? lim : v;
    end
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  wire do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
  wire [31:0] wd = wdata_r;
  wire wr_lo = do_wr && wstrb_r[0];
  wire [`ST_W-1:0] st_events;

  // address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 6'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r > `OFS_STATE || awaddr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  // register stores; only the low byte lane matters for narrow fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      fb_treat_r <= `RST_FB_TREAT;
      ss_treat_r <= `RST_SS_TREAT;
      comm_mode_r <= 1'b0;
      stall_lvl_r <= `RST_STALL_LEVEL;
      slip_rng_r <= `RST_SLIP_RANGE;
      stall_time_r <= `RST_STALL_TIME;
      fb_time_r <= `RST_FB_TIME;
      sw_freq_r <= `RST_SW_FREQ;
      kp1_r <= `RST_KP;
      ti1_r <= `RST_TI;
      kp2_r <= `RST_KP;
      ti2_r <= `RST_TI;
      mask_r <= {`ST_W{1'b0}};
    end else if (do_wr) begin
      case (awaddr_r)
        `OFS_CTRL: begin
          if (wstrb_r[0]) begin
            fb_treat_r <= wd[`CTRL_FB_TREAT_LSB+:2];
            ss_treat_r <= wd[`CTRL_SS_TREAT_LSB+:2];
            comm_mode_r <= wd[`CTRL_COMM_MODE_BIT];
          end
        end
        `OFS_STALL_LEVEL: if (wr_lo)
          stall_lvl_r <= (wd[6:0] > `STALL_MAX_PCT) ? `STALL_MAX_PCT : wd[6:0];
        `OFS_SLIP_RANGE: if (wr_lo)
          slip_rng_r <= (wd[6:0] > `SLIP_MAX_PCT) ? `SLIP_MAX_PCT : wd[6:0];
        `OFS_STALL_TIME: if (&wstrb_r[1:0]) stall_time_r <= clamp14(wd[13:0], `STALL_TIME_MAX_MS);
        `OFS_FB_TIME: if (&wstrb_r[1:0]) fb_time_r <= clamp14(wd[13:0], `FB_TIME_MAX_MS);
        `OFS_SW_FREQ: if (&wstrb_r[1:0]) sw_freq_r <= wd[15:0];
        `OFS_KP1: if (&wstrb_r[1:0]) kp1_r <= (wd[12:0] > `KP_MAX) ? `KP_MAX : wd[12:0];
        `OFS_TI1: if (&wstrb_r[1:0]) ti1_r <= clamp14(wd[13:0], `TI_MAX_MS);
        `OFS_KP2: if (&wstrb_r[1:0]) kp2_r <= (wd[12:0] > `KP_MAX) ? `KP_MAX : wd[12:0];
        `OFS_TI2: if (&wstrb_r[1:0]) ti2_r <= clamp14(wd[13:0], `TI_MAX_MS);
        `OFS_MASK: if (wr_lo) mask_r <= wd[`ST_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status, a new event wins over a write-one clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= {`ST_W{1'b0}};
      irq_r <= 1'b0;
    end else begin
      if (wr_lo && awaddr_r == `OFS_STATUS)
        status_r <= (status_r & ~wd[`ST_W-1:0]) | st_events;
      else
        status_r <= status_r | st_events;
      irq_r <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `OFS_CTRL: s_axi_rdata <= {27'h0, comm_mode_r, ss_treat_r, fb_treat_r};
          `OFS_STALL_LEVEL: s_axi_rdata <= {25'h0, stall_lvl_r};
          `OFS_SLIP_RANGE: s_axi_rdata <= {25'h0, slip_rng_r};
          `OFS_STALL_TIME: s_axi_rdata <= {18'h0, stall_time_r};
          `OFS_FB_TIME: s_axi_rdata <= {18'h0, fb_time_r};
          `OFS_SW_FREQ: s_axi_rdata <= {16'h0, sw_freq_r};
          `OFS_KP1: s_axi_rdata <= {19'h0, kp1_r};
          `OFS_TI1: s_axi_rdata <= {18'h0, ti1_r};
          `OFS_KP2: s_axi_rdata <= {19'h0, kp2_r};
          `OFS_TI2: s_axi_rdata <= {18'h0, ti2_r};
          `OFS_STATUS: s_axi_rdata <= {27'h0, status_r};
          `OFS_MASK: s_axi_rdata <= {27'h0, mask_r};
          `OFS_REG_OUT: s_axi_rdata <= speed_out_r;
          `OFS_STATE: s_axi_rdata <= {28'h0, coast_stop_r, ramp_stop_r, warn_r, gain_sel_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  reg [31:0] tick_cnt_r;
  wire tick = (tick_cnt_r == TICK_CYCLES - 1);

  always @(posedge aclk) begin
    if (!aresetn || tick)
      tick_cnt_r <= 32'h00000000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
  end

  // ----------------------------------------
  // stall and slip supervision
  // ----------------------------------------
  wire [15:0] slip_abs = (meas_speed > cmd_freq) ? meas_speed - cmd_freq : cmd_freq - meas_speed;
  wire [23:0] slip_x100 = slip_abs * `PCT_FULL;
  wire [23:0] meas_x100 = meas_speed * `PCT_FULL;
  wire [23:0] slip_lim = max_freq * slip_rng_r;
  wire [23:0] stall_lim = max_freq * stall_lvl_r;
  wire slip_cond = (slip_rng_r != 7'h00) && (slip_x100 > slip_lim); // [RULE_01] [RULE_11]
  wire stall_cond = (stall_lvl_r != 7'h00) && (meas_x100 > stall_lim); // [RULE_02] [RULE_11]
  reg [13:0] ss_acc_r;
  reg ss_fired_r;
  wire ss_fire = (stall_cond || slip_cond) && (ss_acc_r > stall_time_r) &&
                 !ss_fired_r; // [RULE_03]

  // time accumulates while either condition holds, restarts when both clear
  always @(posedge aclk) begin
    if (!aresetn || !(stall_cond || slip_cond)) begin
      ss_acc_r <= 14'h0000;
      ss_fired_r <= 1'b0;
    end else begin
      if (tick && ss_acc_r != 14'h3fff)
        ss_acc_r <= ss_acc_r + 14'h0001; // [RULE_01] [RULE_02]
      if (ss_fire)
        ss_fired_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // index versus u-phase edge check
  // ----------------------------------------
  reg u_d_r;
  reg idx_d_r;
  reg last_fall_r;
  reg fwd_r;
  reg [4:0] u_age_r;
  wire u_rise = enc_u && !u_d_r;
  wire u_fall = !enc_u && u_d_r;
  wire idx_rise = enc_index && !idx_d_r;
  wire edge_ok = (u_rise || u_fall) ? (u_fall == !comm_mode_r) :
                 (u_age_r < IDX_WIN && last_fall_r == !comm_mode_r); // [RULE_05] [RULE_06]
  wire idx_bad = idx_rise && fwd_r && !edge_ok;

  // direction from v at each u edge: forward sees v low on rise, high on fall
  always @(posedge aclk) begin
    if (!aresetn) begin
      u_d_r <= enc_u; // track the pin so a high idle level is no edge
      idx_d_r <= enc_index;
      last_fall_r <= 1'b0;
      fwd_r <= 1'b0;
      u_age_r <= 5'h1f;
    end else begin
      u_d_r <= enc_u;
      idx_d_r <= enc_index;
      if (u_rise || u_fall) begin
        last_fall_r <= u_fall;
        fwd_r <= u_fall ? enc_v : !enc_v;
        u_age_r <= 5'h00;
      end else if (u_age_r != 5'h1f) begin
        u_age_r <= u_age_r + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // feedback loss and signal error timing
  // ----------------------------------------
  reg sig_err_r;
  reg [13:0] fb_acc_r;
  reg fb_fired_r;
  wire fb_cond = feedback_loss || sig_err_r;
  wire fb_fire = fb_cond && (fb_acc_r > fb_time_r) && !fb_fired_r; // [RULE_10]

  // a wrong index edge counts as a signal error until a good index arrives
  always @(posedge aclk) begin
    if (!aresetn) begin
      sig_err_r <= 1'b0;
      fb_acc_r <= 14'h0000;
      fb_fired_r <= 1'b0;
    end else begin
      if (idx_rise && fwd_r)
        sig_err_r <= !edge_ok;
      if (!fb_cond) begin
        fb_acc_r <= 14'h0000;
        fb_fired_r <= 1'b0;
      end else begin
        if (tick && fb_acc_r != 14'h3fff)
          fb_acc_r <= fb_acc_r + 14'h0001;
        if (fb_fire)
          fb_fired_r <= 1'b1;
      end
    end
  end

  assign st_events = {idx_bad, ss_fire && slip_cond, ss_fire && stall_cond,
                      fb_fire && !feedback_loss, fb_fire && feedback_loss};

  // ----------------------------------------
  // fault treatment
  // ----------------------------------------
  wire fb_flt = status_r[`ST_LOSS] || status_r[`ST_SIGNAL];
  wire ss_flt = status_r[`ST_STALL] || status_r[`ST_SLIP];

  // actions hold while the fault bit stays set
  always @(posedge aclk) begin
    if (!aresetn) begin
      warn_r <= 1'b0;
      ramp_stop_r <= 1'b0;
      coast_stop_r <= 1'b0;
    end else begin
      warn_r <= fb_flt || ss_flt; // [RULE_04] [RULE_10]
      ramp_stop_r <= (fb_flt && fb_treat_r == `TREAT_RAMP) ||
                     (ss_flt && ss_treat_r == `TREAT_RAMP); // [RULE_04] [RULE_10]
      coast_stop_r <= (fb_flt && fb_treat_r == `TREAT_STOP) ||
                      (ss_flt && ss_treat_r == `TREAT_STOP); // [RULE_04] [RULE_10]
    end
  end

  // ----------------------------------------
  // speed regulator
  // ----------------------------------------
  wire use_two = (sw_freq_r != 16'h0000) && (meas_speed > sw_freq_r); // [RULE_09]
  wire [12:0] kp = gain_sel_r ? kp2_r : kp1_r;
  wire [13:0] ti = gain_sel_r ? ti2_r : ti1_r;
  wire signed [16:0] err = $signed({1'b0, cmd_freq}) - $signed({1'b0, meas_speed});
  wire signed [30:0] prod = err * $signed({1'b0, kp});
  wire signed [31:0] p_term = {{11{prod[30]}}, prod[30:10]};
  reg signed [31:0] integ_r;
  reg [13:0] ti_cnt_r;

  // integrator adds the proportional term once per ti milliseconds
  always @(posedge aclk) begin
    if (!aresetn) begin
      gain_sel_r <= 1'b0;
      integ_r <= 32'sh00000000;
      ti_cnt_r <= 14'h0000;
      speed_out_r <= 32'h00000000;
    end else begin
      gain_sel_r <= use_two;
      if (ti == 14'h0000) begin
        integ_r <= 32'sh00000000; // [RULE_08]
        ti_cnt_r <= 14'h0000;
      end else if (tick) begin
        if (ti_cnt_r >= ti - 14'h0001) begin
          ti_cnt_r <= 14'h0000;
          integ_r <= integ_r + p_term; // [RULE_07]
        end else begin
          ti_cnt_r <= ti_cnt_r + 14'h0001;
        end
      end
      speed_out_r <= p_term + integ_r; // [RULE_07]
    end
  end

endmodule // encoder_fault_speed_regulator

// ==== verilog/encoder_fault_speed_regulator_consts.vh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock, AXI4-Lite byte addresses
// Notes:   definitions only
`ifndef ENCODER_FAULT_SPEED_REGULATOR_CONSTS_VH
`define ENCODER_FAULT_SPEED_REGULATOR_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 6'h00
`define OFS_STALL_LEVEL 6'h04
`define OFS_SLIP_RANGE 6'h08
`define OFS_STALL_TIME 6'h0c
`define OFS_FB_TIME 6'h10
`define OFS_SW_FREQ 6'h14
`define OFS_KP1 6'h18
`define OFS_TI1 6'h1c
`define OFS_KP2 6'h20
`define OFS_TI2 6'h24
`define OFS_STATUS 6'h28
`define OFS_MASK 6'h2c
`define OFS_REG_OUT 6'h30
`define OFS_STATE 6'h34

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_FB_TREAT_LSB 0
`define CTRL_SS_TREAT_LSB 2
`define CTRL_COMM_MODE_BIT 4

// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_LOSS 0
`define ST_SIGNAL 1
`define ST_STALL 2
`define ST_SLIP 3
`define ST_INDEX 4
`define ST_W 5

// ----------------------------------------
// treatment codes and limits
// ----------------------------------------
`define TREAT_KEEP 2'h0
`define TREAT_RAMP 2'h1
`define TREAT_STOP 2'h2
`define STALL_MAX_PCT 7'h78
`define SLIP_MAX_PCT 7'h32
`define PCT_FULL 8'h64

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_FB_TREAT 2'h2
`define RST_SS_TREAT 2'h2
`define RST_STALL_LEVEL 7'h73
`define RST_SLIP_RANGE 7'h32
`define RST_STALL_TIME 14'h0064
`define RST_FB_TIME 14'h03e8
`define RST_SW_FREQ 16'h02bc
`define RST_KP 13'h03e8
`define RST_TI 14'h0064

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define MS_TICK_NS 1000000
`define MS_TICK_CYCLES (`MS_TICK_NS / `CLK_PERIOD_NS)
`define STALL_TIME_MAX_MS 14'h07d0
`define FB_TIME_MAX_MS 14'h2710
`define TI_MAX_MS 14'h2710
`define KP_MAX 13'h1388

`endif
